// file: logic/uig_pkg.sv
package uig_pkg;
    // ----------------------------------------------------------------
    // register byte offsets (apb, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_DIV_LO = 8'h00;
    localparam logic [7:0] OFS_DIV_HI = 8'h04;
    localparam logic [7:0] OFS_IER = 8'h08;
    localparam logic [7:0] OFS_ISR = 8'h0c;
    localparam logic [7:0] OFS_SCRATCH = 8'h10;
    localparam logic [7:0] OFS_FIFO_CTRL = 8'h14;
    localparam logic [7:0] OFS_MODEM_CTRL = 8'h18;
    localparam logic [7:0] OFS_CLK_CFG = 8'h1c;
    localparam logic [7:0] OFS_LINE_STAT = 8'h20;
    localparam logic [7:0] OFS_MODEM_STAT = 8'h24;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int IER_RX = 0;
    localparam int IER_TXE = 1;
    localparam int IER_LINE = 2;
    localparam int IER_MODEM = 3;
    localparam int FCR_FIFO_EN = 0;
    localparam int MCR_IRQ_OE = 3;
    localparam int CFG_HS = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ----------------------------------------------------------------
    // identification codes, bits 3:0
    // ----------------------------------------------------------------
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_LINE = 4'h6;
    localparam logic [3:0] ID_RX = 4'h4;
    localparam logic [3:0] ID_TMO = 4'hc;
    localparam logic [3:0] ID_TXE = 4'h2;
    localparam logic [3:0] ID_MODEM = 4'h0;

    // ----------------------------------------------------------------
    // clocks: 24 mhz reference synthesised from the 40 mhz bus clock
    // ----------------------------------------------------------------
    localparam int SYS_KHZ = 40000;
    localparam int REF_KHZ = 24000;
    localparam int REF_STEP = REF_KHZ / 1000;
    localparam int REF_MOD = SYS_KHZ / 1000;
    // pre-divider as a fraction: 13/step, step 1 -> 13, 8 -> 1.625
    localparam logic [4:0] PRE_MOD = 5'h0d;
    localparam logic [4:0] PRE_STEP_13 = 5'h01;
    localparam logic [4:0] PRE_STEP_1625 = 5'h08;
    localparam logic [4:0] PRE_STEP_1 = 5'h0d;
    localparam int BAUD_OVERSAMPLE = 16;
    localparam int CHAR_BITS = 10;
    localparam int CHAR_TIMES = 4;

    typedef struct packed {
        logic silent;
        logic no_stop;
        logic parity;
        logic overrun;
    } uig_line_ev_t;

    typedef struct packed {
        logic dcd;
        logic ring;
        logic dsr;
        logic cts;
    } uig_modem_ev_t;
endpackage : uig_pkg

// file: logic/uig_top.sv
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module uig_top #(
    parameter int CHAR_TICKS = uig_pkg::CHAR_BITS * uig_pkg::BAUD_OVERSAMPLE
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receiver side
    input wire uig_pkg::uig_line_ev_t line_ev,
    input wire logic rx_data_ready,
    input wire logic rx_fifo_trig,
    input wire logic rx_fifo_nonempty,
    input wire logic rx_push,
    input wire logic rx_read,
    // transmitter side
    input wire logic tx_empty,
    input wire logic tx_write,
    // modem lines
    input wire uig_pkg::uig_modem_ev_t modem_ev,
    // outputs to the port
    output logic irq_out,
    output logic baud16_tick,
    output logic fifo_enable
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // hardware set beats a software clear in the same cycle
    function automatic logic [3:0] sticky(input logic [3:0] cur,
                                          input logic [3:0] set,
                                          input logic clr);
        sticky = set | (cur & {4{~clr}});
    endfunction : sticky

    localparam int TMO_TICKS = uig_pkg::CHAR_TIMES * CHAR_TICKS;
    localparam int TMO_W = $clog2(TMO_TICKS + 1);
    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TMO_TICKS - 1);
    localparam logic [5:0] REF_STEP6 = 6'(uig_pkg::REF_STEP);
    localparam logic [5:0] REF_MOD6 = 6'(uig_pkg::REF_MOD);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] div_lo_r;
    logic [7:0] div_hi_r;
    logic [3:0] ier_r;
    logic [7:0] scratch_r;
    logic [7:0] fcr_r;
    logic [7:0] mcr_r;
    logic [2:0] cfg_r;
    logic [3:0] line_r;
    logic [3:0] line_nxt;
    logic [3:0] modem_r;
    logic [3:0] modem_nxt;
    logic txe_pend_r;
    logic txe_pend_nxt;
    logic tx_empty_d_r;
    logic tmo_pend_r;
    logic [TMO_W-1:0] tmo_cnt_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic irq_r;
    logic [5:0] ref_acc_r;
    logic [4:0] pre_acc_r;
    logic [15:0] div_cnt_r;
    logic baud_r;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    // one wait state: pready comes from a flop so the answer is stable
    wire logic setup_acc = psel & penable & ~pready_r;
    wire logic acc = psel & penable & pready_r;
    wire logic wr_acc = acc & pwrite;
    wire logic rd_acc = acc & ~pwrite;
    wire logic sel_div_lo = paddr == uig_pkg::OFS_DIV_LO;
    wire logic sel_div_hi = paddr == uig_pkg::OFS_DIV_HI;
    wire logic sel_ier = paddr == uig_pkg::OFS_IER;
    wire logic sel_isr = paddr == uig_pkg::OFS_ISR;
    wire logic sel_scr = paddr == uig_pkg::OFS_SCRATCH;
    wire logic sel_fcr = paddr == uig_pkg::OFS_FIFO_CTRL;
    wire logic sel_mcr = paddr == uig_pkg::OFS_MODEM_CTRL;
    wire logic sel_cfg = paddr == uig_pkg::OFS_CLK_CFG;
    wire logic sel_lsr = paddr == uig_pkg::OFS_LINE_STAT;
    wire logic sel_msr = paddr == uig_pkg::OFS_MODEM_STAT;
    wire logic mapped = sel_div_lo | sel_div_hi | sel_ier | sel_isr |
                        sel_scr | sel_fcr | sel_mcr | sel_cfg |
                        sel_lsr | sel_msr;
    // read-only registers refuse writes with an error
    wire logic bad = ~mapped | (pwrite & (sel_isr | sel_lsr | sel_msr));

    // ----------------------------------------------------------------
    // interrupt sources and priority
    // ----------------------------------------------------------------
    wire logic fifo_en = fcr_r[uig_pkg::FCR_FIFO_EN];
    wire logic src_line = |line_r & ier_r[uig_pkg::IER_LINE];
    wire logic src_rx = (rx_data_ready | rx_fifo_trig) &
                        ier_r[uig_pkg::IER_RX];
    wire logic src_tmo = tmo_pend_r & fifo_en &
                         ier_r[uig_pkg::IER_RX];
    wire logic src_txe = txe_pend_r & ier_r[uig_pkg::IER_TXE];
    wire logic src_modem = |modem_r & ier_r[uig_pkg::IER_MODEM];
    wire logic any_pend = src_line | src_rx | src_tmo | src_txe | src_modem;
    wire logic [3:0] id_code =
        src_line ? uig_pkg::ID_LINE :
        src_rx ? uig_pkg::ID_RX :
        src_tmo ? uig_pkg::ID_TMO :
        src_txe ? uig_pkg::ID_TXE :
        src_modem ? uig_pkg::ID_MODEM :
        uig_pkg::ID_NONE;
    wire logic [7:0] isr_val = {{2{fifo_en}}, 2'b00, id_code};

    wire logic [7:0] rd_byte =
        sel_div_lo ? div_lo_r :
        sel_div_hi ? div_hi_r :
        sel_ier ? {4'h0, ier_r} :
        sel_isr ? isr_val :
        sel_scr ? scratch_r :
        sel_fcr ? fcr_r :
        sel_mcr ? mcr_r :
        sel_cfg ? {5'h00, cfg_r} :
        sel_lsr ? {3'h0, line_r, 1'b0} :
        sel_msr ? {4'h0, modem_r} :
        8'h00;

    // ----------------------------------------------------------------
    // sticky flag next values
    // ----------------------------------------------------------------
    wire logic txe_rise = tx_empty & ~tx_empty_d_r;
    wire logic isr_clr_txe = rd_acc & sel_isr & (id_code == uig_pkg::ID_TXE);
    assign line_nxt = sticky(line_r, line_ev, rd_acc & sel_lsr);
    assign modem_nxt = sticky(modem_r, modem_ev, rd_acc & sel_msr);
    assign txe_pend_nxt = txe_rise |
        (txe_pend_r & ~tx_write & ~isr_clr_txe);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_r <= 4'h0;
            modem_r <= 4'h0;
            txe_pend_r <= 1'b0;
            tx_empty_d_r <= 1'b0;
        end else begin
            line_r <= line_nxt;
            modem_r <= modem_nxt;
            txe_pend_r <= txe_pend_nxt;
            tx_empty_d_r <= tx_empty;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_lo_r <= uig_pkg::RST_BYTE;
            div_hi_r <= uig_pkg::RST_BYTE;
            ier_r <= 4'h0;
            scratch_r <= uig_pkg::RST_BYTE;
            fcr_r <= uig_pkg::RST_BYTE;
            mcr_r <= uig_pkg::RST_BYTE;
            cfg_r <= 3'h0;
        end else if (wr_acc) begin
            if (sel_div_lo) div_lo_r <= pwdata[7:0];
            if (sel_div_hi) div_hi_r <= pwdata[7:0];
            if (sel_ier) ier_r <= pwdata[3:0];
            if (sel_scr) scratch_r <= pwdata[7:0];
            if (sel_fcr) fcr_r <= pwdata[7:0];
            if (sel_mcr) mcr_r <= pwdata[7:0];
            if (sel_cfg) cfg_r <= pwdata[2:0];
        end
    end

    // ----------------------------------------------------------------
    // apb answer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup_acc;
            pslverr_r <= setup_acc & bad;
            prdata_r <= (setup_acc & ~pwrite & ~bad) ? {24'h000000, rd_byte}
                                                     : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // interrupt output
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= any_pend & mcr_r[uig_pkg::MCR_IRQ_OE];
        end
    end

    // ----------------------------------------------------------------
    // receive timeout, counted in 16x ticks
    // ----------------------------------------------------------------
    // any fifo access restarts the four character window
    wire logic rx_touch = rx_push | rx_read | ~rx_fifo_nonempty;
    wire logic tmo_hit = baud_r & (tmo_cnt_r == TMO_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmo_cnt_r <= '0;
            tmo_pend_r <= 1'b0;
        end else begin
            if (rx_touch) begin
                tmo_cnt_r <= '0;
            end else if (baud_r & ~tmo_hit) begin
                tmo_cnt_r <= tmo_cnt_r + 1'b1;
            end
            if (rx_read | ~rx_fifo_nonempty) begin
                tmo_pend_r <= 1'b0;
            end else if (tmo_hit & ~rx_touch) begin
                tmo_pend_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // baud generator
    // ----------------------------------------------------------------
    // the 24 mhz reference is an enable at 24/40 of the bus clock, so
    // ticks jitter by one bus cycle; average rates are exact
    wire logic [6:0] ref_sum = {1'b0, ref_acc_r} + {1'b0, REF_STEP6};
    wire logic ref_tick = ref_sum >= {1'b0, REF_MOD6};
    wire logic high_speed = cfg_r[uig_pkg::CFG_HS];
    wire logic [4:0] pre_step =
        (high_speed | cfg_r[1]) ? uig_pkg::PRE_STEP_1 :
        cfg_r[0] ? uig_pkg::PRE_STEP_1625 :
        uig_pkg::PRE_STEP_13;
    wire logic [5:0] pre_sum = {1'b0, pre_acc_r} + {1'b0, pre_step};
    wire logic pre_tick = ref_tick & (pre_sum >= {1'b0, uig_pkg::PRE_MOD});
    wire logic [15:0] divisor = {div_hi_r, div_lo_r};
    // divisor zero parks the generator
    wire logic div_wrap = div_cnt_r >= divisor - 16'h0001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_acc_r <= 6'h00;
            pre_acc_r <= 5'h00;
            div_cnt_r <= 16'h0000;
            baud_r <= 1'b0;
        end else begin
            ref_acc_r <= ref_tick ? 6'(ref_sum - {1'b0, REF_MOD6})
                                  : ref_sum[5:0];
            if (ref_tick) begin
                pre_acc_r <= pre_tick
                    ? 5'(pre_sum - {1'b0, uig_pkg::PRE_MOD})
                    : pre_sum[4:0];
            end
            baud_r <= 1'b0;
            if (divisor == 16'h0000) begin
                div_cnt_r <= 16'h0000;
            end else if (pre_tick) begin
                if (div_wrap) begin
                    div_cnt_r <= 16'h0000;
                    baud_r <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 16'h0001;
                end
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq_out = irq_r;
    assign baud16_tick = baud_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_enable <= 1'b0;
        end else begin
            fifo_enable <= fcr_r[uig_pkg::FCR_FIFO_EN];
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_line_first: assert property (@(posedge pclk) disable iff (!presetn)
        src_line |-> id_code == uig_pkg::ID_LINE)
        else $error("line error not reported first");

    a_line_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && sel_lsr && line_ev == 4'h0) |=> line_r == 4'h0)
        else $error("line flags not cleared by status read");

    a_rx_second: assert property (@(posedge pclk) disable iff (!presetn)
        (src_rx && !src_line) |-> isr_val[3:0] == uig_pkg::ID_RX)
        else $error("rx ready code wrong");

    a_tmo_window: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(tmo_pend_r) |-> $past(tmo_cnt_r) == TMO_LAST)
        else $error("timeout raised outside four characters");

    a_txe_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_write && !txe_rise) |=> !txe_pend_r)
        else $error("tx empty not cleared by write");

    a_tmo_fifo_only: assert property (@(posedge pclk) disable iff (!presetn)
        !fifo_en |-> !isr_val[3])
        else $error("timeout bit without fifo mode");

    a_ier_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (pready_r && !pwrite && sel_ier) |-> prdata_r[7:4] == 4'h0)
        else $error("enable upper bits not zero");

    a_modem_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !ier_r[uig_pkg::IER_MODEM] |-> isr_val[3:0] != uig_pkg::ID_MODEM)
        else $error("modem source shown while disabled");

    a_mask_all_off: assert property (@(posedge pclk) disable iff (!presetn)
        (ier_r == 4'h0) |=> !irq_r)
        else $error("interrupt with all enables clear");

    a_none_bit0: assert property (@(posedge pclk) disable iff (!presetn)
        isr_val[0] == !any_pend)
        else $error("isr bit 0 disagrees with pending state");

    a_irq_oe_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !mcr_r[uig_pkg::MCR_IRQ_OE] |=> !irq_r)
        else $error("interrupt out while output disabled");

    a_scratch_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && sel_scr) |=> scratch_r == $past(pwdata[7:0]))
        else $error("scratch byte not kept");

    a_baud_div_one: assert property (@(posedge pclk) disable iff (!presetn)
        (divisor == 16'h0001 && pre_tick) |=> baud_r)
        else $error("divisor one does not tick every reference");

    c_line_then_rx: cover property (@(posedge pclk) disable iff (!presetn)
        src_line && src_rx ##1 rd_acc && sel_lsr ##2 id_code == uig_pkg::ID_RX);
    c_timeout: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(tmo_pend_r));
    c_txe_isr_clear: cover property (@(posedge pclk) disable iff (!presetn)
        isr_clr_txe);
    c_baud_tick: cover property (@(posedge pclk) disable iff (!presetn)
        baud_r && high_speed);
endmodule : uig_top

// file: verif/uig_host.sv
`timescale 1ns/1ps
module uig_host (
    // clock
    input wire logic pclk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // entered right after a rising edge; returns one edge after the answer
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic ok);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        ok = (pready === 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show the inverse so stale values are never trusted
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask : xfer
endmodule : uig_host

// file: verif/uig_tb.sv
`timescale 1ns/1ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    uig_pkg::uig_line_ev_t line_ev;
    uig_pkg::uig_modem_ev_t modem_ev;
    logic rx_data_ready, rx_fifo_trig, rx_fifo_nonempty, rx_push, rx_read;
    logic tx_empty, tx_write, irq_out, baud16_tick, fifo_enable;
    logic [32:0] expq[$];
    int n_mismatch = 0;
    int comparisons = 0;
    int seed = 49195;
    int ticks;
    int n;
    logic [7:0] rv;
    logic [4:0] steps[4] = '{5'h01, 5'h08, 5'h0d, 5'h0d};
    logic [7:0] cfgs[4] = '{8'h00, 8'h01, 8'h02, 8'h04};

    always #12.5 pclk = ~pclk;

    uig_top #(.CHAR_TICKS(4)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_ev(line_ev),
        .rx_data_ready(rx_data_ready), .rx_fifo_trig(rx_fifo_trig),
        .rx_fifo_nonempty(rx_fifo_nonempty), .rx_push(rx_push),
        .rx_read(rx_read), .tx_empty(tx_empty), .tx_write(tx_write),
        .modem_ev(modem_ev), .irq_out(irq_out), .baud16_tick(baud16_tick),
        .fifo_enable(fifo_enable));

    uig_host host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    task automatic chk(string name, logic [32:0] seen, logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    // ----------------------------------------------------------------
    // bus access: note the expected answer, then run the transfer
    // ----------------------------------------------------------------
    task automatic acc(logic w, logic [7:0] a, logic [31:0] d,
                       logic [31:0] x, logic e);
        logic ok;
        expq.push_back({e, w ? 32'h0 : x});
        host.xfer(w, a, d, ok);
        if (!ok) begin
            n_mismatch++;
            summarize();
        end
    endtask : acc

    // ----------------------------------------------------------------
    // monitor: every answer is matched against the oldest note
    // ----------------------------------------------------------------
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (expq.size() == 0)
                chk("unexpected answer", 33'h1, 33'h0);
            else
                chk("apb answer", {pslverr, pwrite ? 32'h0 : prdata},
                    expq.pop_front());
        end
    end

    initial begin
        {line_ev, modem_ev, rx_data_ready, rx_fifo_trig} = '0;
        {rx_fifo_nonempty, rx_push, rx_read, tx_empty, tx_write} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // registers: reset, masked bits, scratch, refusals
        acc(0, uig_pkg::OFS_IER, 0, 32'h0, 0);
        acc(1, uig_pkg::OFS_IER, 32'hff, 0, 0);
        acc(0, uig_pkg::OFS_IER, 0, 32'h0f, 0);
        for (int i = 0; i < 4; i++) begin
            rv = 8'($random(seed));
            acc(1, uig_pkg::OFS_SCRATCH, {24'h0, rv}, 0, 0);
            acc(0, uig_pkg::OFS_SCRATCH, 0, {24'h0, rv}, 0);
            acc(0, uig_pkg::OFS_DIV_LO, 0, 32'h0, 0);
        end
        acc(1, uig_pkg::OFS_ISR, 32'h5, 0, 1);
        acc(0, 8'h28, 0, 32'h0, 1);
        $display("registers done");
        // interrupts: every source but the timeout pending with all enables off
        acc(1, uig_pkg::OFS_IER, 32'h0, 0, 0);
        acc(1, uig_pkg::OFS_MODEM_CTRL, 32'h8, 0, 0);
        line_ev <= 4'hf;
        modem_ev <= 4'hf;
        tx_empty <= 1'b1;
        rx_data_ready <= 1'b1;
        @(posedge pclk);
        line_ev <= 4'h0;
        modem_ev <= 4'h0;
        repeat (3) @(posedge pclk);
        chk("irq_out", irq_out, 0);
        acc(0, uig_pkg::OFS_ISR, 0, 32'h01, 0);
        acc(1, uig_pkg::OFS_IER, 32'h0b, 0, 0);
        acc(0, uig_pkg::OFS_ISR, 0, 32'h04, 0);
        acc(1, uig_pkg::OFS_IER, 32'h0f, 0, 0);
        repeat (2) @(posedge pclk);
        chk("irq_out", irq_out, 1);
        acc(1, uig_pkg::OFS_MODEM_CTRL, 32'h0, 0, 0);
        repeat (2) @(posedge pclk);
        chk("irq_out", irq_out, 0);
        acc(1, uig_pkg::OFS_MODEM_CTRL, 32'h8, 0, 0);
        acc(0, uig_pkg::OFS_ISR, 0, 32'h06, 0);
        acc(0, uig_pkg::OFS_LINE_STAT, 0, 32'h1e, 0);
        acc(0, uig_pkg::OFS_ISR, 0, 32'h04, 0);
        rx_data_ready <= 1'b0;
        acc(1, uig_pkg::OFS_IER, 32'h09, 0, 0);
        acc(0, uig_pkg::OFS_ISR, 0, 32'h00, 0);
        acc(1, uig_pkg::OFS_IER, 32'h0f, 0, 0);
        acc(0, uig_pkg::OFS_ISR, 0, 32'h02, 0);
        acc(0, uig_pkg::OFS_ISR, 0, 32'h00, 0);
        acc(0, uig_pkg::OFS_MODEM_STAT, 0, 32'h0f, 0);
        acc(0, uig_pkg::OFS_ISR, 0, 32'h01, 0);
        chk("irq_out", irq_out, 0);
        // a fresh empty edge raises tx pending, a transmit write drops it
        tx_empty <= 1'b0;
        @(posedge pclk);
        tx_empty <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("irq_out", irq_out, 1);
        tx_write <= 1'b1;
        @(posedge pclk);
        tx_write <= 1'b0;
        acc(0, uig_pkg::OFS_ISR, 0, 32'h01, 0);
        // the fifo trigger level alone also reports receive ready
        rx_fifo_trig <= 1'b1;
        acc(0, uig_pkg::OFS_ISR, 0, 32'h04, 0);
        rx_fifo_trig <= 1'b0;
        $display("interrupts done");
        // baud generator: ticks over 1000 cycles for each pre-divider
        for (int i = 0; i < 4; i++) begin
            acc(1, uig_pkg::OFS_CLK_CFG, {24'h0, cfgs[i]}, 0, 0);
            acc(1, uig_pkg::OFS_DIV_LO, i + 1, 0, 0);
            acc(1, uig_pkg::OFS_DIV_HI, 0, 0, 0);
            ticks = 0;
            repeat (1000) begin
                @(posedge pclk);
                ticks += (baud16_tick === 1'b1);
            end
            n = 24000 * int'(steps[i]) / (520 * (i + 1)) - ticks;
            chk("baud ticks", n <= 1 && n >= -1, 1);
        end
        $display("baud done");
        // receive timeout with the fifo enabled
        acc(1, uig_pkg::OFS_FIFO_CTRL, 32'h1, 0, 0);
        rx_fifo_nonempty <= 1'b1;
        rx_push <= 1'b1;
        @(posedge pclk);
        rx_push <= 1'b0;
        n = 0;
        while (irq_out !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 400) begin
            n_mismatch++;
            summarize();
        end
        chk("fifo_enable", fifo_enable, 1);
        acc(0, uig_pkg::OFS_ISR, 0, 32'hcc, 0);
        rx_read <= 1'b1;
        rx_fifo_nonempty <= 1'b0;
        @(posedge pclk);
        rx_read <= 1'b0;
        acc(0, uig_pkg::OFS_ISR, 0, 32'hc1, 0);
        $display("timeout done");
        summarize();
    end
endmodule : tb
